// ==== hw/ram_ecc_err_regs.sv ====
/*
 * Sticky RAM ECC / FIFO overflow status with per-bit mask, interrupt request,
 * and the upstream port selection held in the debug control register.
 * Assumes error inputs are one-cycle (or level) pulses synchronous to clk,
 * srst is the fundamental reset, and the interrupt enable comes from the
 * port's MSI/INTx logic.
 */
// Notes on behaviour
// - Bits 4,5 set on link-list RAM instance 0/1 double-bit errors.
// - Bits 6,7 set on link-list RAM instance 0/1 single-bit errors.
// - Bit 8 source queue single-bit counter overflow; bit 9 double-bit error.
// - Retry buffer: bit 10 single-bit counter overflow, bit 11 double-bit error.
// - Bits 12-14 set on scheduler RAM double-bit errors, stations 0-2.
// - Bits 16-18 set on scheduler RAM single-bit errors, stations 0-2.
// - Bits 20-22 set on transaction ID RAM double-bit errors, stations 0-2.
// - Bits 24-26 set on transaction ID RAM counter overflows, stations 0-2.
// - Mask register bit set suppresses reporting of matching status bit.
// - Unmasked completion FIFO overflow raises interrupt when interrupts enabled.
// - RAM bits exist on ports 0, 8, 12; FIFO bits on nine ports.
// - Without software control, port number loads from straps; writes ignored.
// - Debug control bit 15: 0 straps decide, 1 software decides.
// - Every recorded error can raise the interrupt when unmasked and enabled.
`timescale 1ns/1ps
module ram_ecc_err_regs
	import ram_ecc_err_pkg::*;
#(
	parameter int unsigned PORT_NUM = 0
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [CFG_ADDR_W-1:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	input wire logic cpl_fifo_ovf,
	input wire logic hdr_fifo_ovf,
	input wire logic [1:0] dq_ll_2bit_err,
	input wire logic [1:0] dq_ll_1bit_err,
	input wire logic sq_ll_1bit_ovf,
	input wire logic sq_ll_2bit_err,
	input wire logic retry_1bit_ovf,
	input wire logic retry_2bit_err,
	input wire logic [2:0] sched_2bit_err,
	input wire logic [2:0] sched_1bit_err,
	input wire logic [2:0] tlpid_2bit_err,
	input wire logic [2:0] tlpid_1bit_ovf,
	input wire logic int_enable,
	input wire logic [UPSTREAM_PORT_W-1:0] upstream_port_select_straps,
	output logic irq_request,
	output logic [UPSTREAM_PORT_W-1:0] upstream_port_num,
	output logic sw_config
);
	localparam bit RAM_PORT = (PORT_NUM == 0) || (PORT_NUM == 8) || (PORT_NUM == 12);
	localparam bit FIFO_PORT = RAM_PORT || (PORT_NUM == 1) || (PORT_NUM == 2) || (PORT_NUM == 9) ||
		(PORT_NUM == 10) || (PORT_NUM == 13) || (PORT_NUM == 14);
	localparam logic [31:0] STATUS_IMPL = (RAM_PORT ? RAM_BITS : 32'h0000_0000) | FIFO_BITS;
	localparam logic [31:0] MASK_IMPL = STATUS_IMPL | FACTORY_MASK;
	// Debug control only exists on port 0
	localparam bit DBG_PORT = (PORT_NUM == 0);

	localparam int unsigned DBG_FACTORY_RO_W = $bits(DBG_FACTORY_RO);

	// Elaboration checks: an unknown port, or package layouts that collide
	if (!FIFO_PORT) begin : g_bad_port
		$error("PORT_NUM is not one of the nine switch ports");
	end
	if ((RAM_BITS & FIFO_BITS) != 32'h0000_0000) begin : g_bits_overlap
		$error("RAM and FIFO status bits overlap");
	end
	if (((RAM_BITS | FIFO_BITS) & FACTORY_MASK) != 32'h0000_0000) begin : g_factory_overlap
		$error("Factory mask bit overlaps an event bit");
	end
	if (UPSTREAM_PORT_LSB + UPSTREAM_PORT_W > SW_CONFIG_BIT) begin : g_port_field
		$error("Upstream port field runs into the control source bit");
	end
	if (DBG_FACTORY_RO_LSB + DBG_FACTORY_RO_W > DBG_FACTORY_RW_BIT) begin : g_factory_field
		$error("Factory read-only field runs into the factory storage bit");
	end

	// Register write decode, shared by every write-side group
	function automatic logic wr_hit(
		input logic wr,
		input logic [CFG_ADDR_W-1:0] addr,
		input logic [CFG_ADDR_W-1:0] ofs
	);
		return wr && (addr == ofs);
	endfunction

	logic [31:0] status, next_status;
	logic [31:0] mask, next_mask;
	logic [UPSTREAM_PORT_W-1:0] next_upstream_port_num;
	logic next_sw_config;
	logic factory_rw, next_factory_rw;
	logic strap_pending, next_strap_pending;
	logic [31:0] next_cfg_rdata;
	logic [31:0] events;
	logic [31:0] dbg_read;

	always_comb begin
		// Levels: a held error keeps re-setting its bit after a clear
		events = 32'h0000_0000;
		events[CPL_FIFO_OVF_BIT] = cpl_fifo_ovf;
		events[HDR_FIFO_OVF_BIT] = hdr_fifo_ovf;
		events[DQ_LL_2BIT_LSB +: 2] = dq_ll_2bit_err;
		events[DQ_LL_1BIT_LSB +: 2] = dq_ll_1bit_err;
		events[SQ_LL_1BIT_OVF_BIT] = sq_ll_1bit_ovf;
		events[SQ_LL_2BIT_BIT] = sq_ll_2bit_err;
		events[RETRY_1BIT_OVF_BIT] = retry_1bit_ovf;
		events[RETRY_2BIT_BIT] = retry_2bit_err;
		events[SCHED_2BIT_LSB +: 3] = sched_2bit_err;
		events[SCHED_1BIT_LSB +: 3] = sched_1bit_err;
		events[TLPID_2BIT_LSB +: 3] = tlpid_2bit_err;
		events[TLPID_1BIT_OVF_LSB +: 3] = tlpid_1bit_ovf;
	end

	// Status and mask
	always_comb begin
		next_status = status;
		next_mask = mask;
		// Of the resets only srst clears status; hot reset never reaches here
		// write-one-clear, set wins
		if (wr_hit(cfg_wr, cfg_addr, RAM_ERROR_STATUS_OFS)) begin
			next_status = status & ~cfg_wdata;
		end
		next_status = (next_status | events) & STATUS_IMPL;
		if (wr_hit(cfg_wr, cfg_addr, RAM_ERROR_MASK_OFS)) begin
			next_mask = cfg_wdata & MASK_IMPL;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			status <= STATUS_RESET;
			mask <= MASK_IMPL;
		end else begin
			status <= next_status;
			mask <= next_mask;
		end
	end

	// Combinational so an unmask or enable acts in the same cycle
	// unmasked status gated by enable
	assign irq_request = int_enable && |(status & ~mask & STATUS_IMPL);

	// Upstream port selection; strap sampled on first edge after reset release
	always_comb begin
		next_upstream_port_num = upstream_port_num;
		next_sw_config = sw_config;
		next_factory_rw = factory_rw;
		next_strap_pending = 1'b0;
		// Straps are not range checked; codes above 2h are the system's to avoid
		// straps load at reset release
		if (strap_pending) begin
			next_upstream_port_num = upstream_port_select_straps;
		end
		if (DBG_PORT && wr_hit(cfg_wr, cfg_addr, DEBUG_CONTROL_OFS)) begin
			next_sw_config = cfg_wdata[SW_CONFIG_BIT];
			next_factory_rw = cfg_wdata[DBG_FACTORY_RW_BIT];
			// software writes only when it owns the field
			if (sw_config && !strap_pending) begin
				next_upstream_port_num = cfg_wdata[UPSTREAM_PORT_LSB +: UPSTREAM_PORT_W];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			upstream_port_num <= '0;
			sw_config <= 1'b0;
			factory_rw <= 1'b0;
			strap_pending <= 1'b1;
		end else begin
			upstream_port_num <= next_upstream_port_num;
			sw_config <= next_sw_config;
			factory_rw <= next_factory_rw;
			strap_pending <= next_strap_pending;
		end
	end

	// A read in the cycle of a write returns the old value
	// Register read, one cycle latency; unmapped offsets read zero
	always_comb begin
		dbg_read = 32'h0000_0000;
		dbg_read[DBG_FACTORY_RO_LSB +: DBG_FACTORY_RO_W] = DBG_FACTORY_RO;
		dbg_read[DBG_FACTORY_RW_BIT] = factory_rw;
		dbg_read[UPSTREAM_PORT_LSB +: UPSTREAM_PORT_W] = upstream_port_num;
		dbg_read[SW_CONFIG_BIT] = sw_config;
		next_cfg_rdata = cfg_rdata;
		if (cfg_rd) begin
			unique case (cfg_addr)
				RAM_ERROR_STATUS_OFS: next_cfg_rdata = status & STATUS_IMPL;
				RAM_ERROR_MASK_OFS: next_cfg_rdata = mask & MASK_IMPL;
				DEBUG_CONTROL_OFS: next_cfg_rdata = DBG_PORT ? dbg_read : 32'h0000_0000;
				default: next_cfg_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_rdata <= 32'h0000_0000;
		end else begin
			cfg_rdata <= next_cfg_rdata;
		end
	end
endmodule // ram_ecc_err_regs

// ==== hw/ram_ecc_err_pkg.sv ====
/*
 * Constants for the RAM ECC error status, mask and debug control registers.
 * Assumes a 32-bit configuration register port addressed by byte offset.
 */
package ram_ecc_err_pkg;
	localparam int unsigned CFG_ADDR_W = 12;
	localparam logic [CFG_ADDR_W-1:0] RAM_ERROR_STATUS_OFS = 12'h1cc;
	localparam logic [CFG_ADDR_W-1:0] RAM_ERROR_MASK_OFS = 12'h1d0;
	localparam logic [CFG_ADDR_W-1:0] DEBUG_CONTROL_OFS = 12'h1dc;

	// Status bit positions
	localparam int unsigned CPL_FIFO_OVF_BIT = 0;
	localparam int unsigned HDR_FIFO_OVF_BIT = 1;
	localparam int unsigned FACTORY_BIT = 2;
	localparam int unsigned DQ_LL_2BIT_LSB = 4;
	localparam int unsigned DQ_LL_1BIT_LSB = 6;
	localparam int unsigned SQ_LL_1BIT_OVF_BIT = 8;
	localparam int unsigned SQ_LL_2BIT_BIT = 9;
	localparam int unsigned RETRY_1BIT_OVF_BIT = 10;
	localparam int unsigned RETRY_2BIT_BIT = 11;
	localparam int unsigned SCHED_2BIT_LSB = 12;
	localparam int unsigned SCHED_1BIT_LSB = 16;
	localparam int unsigned TLPID_2BIT_LSB = 20;
	localparam int unsigned TLPID_1BIT_OVF_LSB = 24;

	// Bits present on every port and bits present only on RAM-owning ports
	localparam logic [31:0] FIFO_BITS = 32'h0000_0003;
	localparam logic [31:0] RAM_BITS = 32'h0777_7ff0;
	localparam logic [31:0] FACTORY_MASK = 32'h0000_0004;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

	// Debug control fields
	localparam int unsigned UPSTREAM_PORT_LSB = 8;
	localparam int unsigned UPSTREAM_PORT_W = 4;
	localparam int unsigned SW_CONFIG_BIT = 15;
	localparam logic [3:0] DBG_FACTORY_RO = 4'hf;
	localparam int unsigned DBG_FACTORY_RO_LSB = 0;
	localparam int unsigned DBG_FACTORY_RW_BIT = 7;
endpackage

// ==== bench/ram_ecc_err_monitor.sv ====
/* Assertions on the ports of ram_ecc_err_regs.
   Assumes PORT_NUM 0, so the debug control register is present. */
`timescale 1ns/1ps
module ram_ecc_err_monitor
	import ram_ecc_err_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [CFG_ADDR_W-1:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic cpl_fifo_ovf,
	input wire logic int_enable,
	input wire logic [UPSTREAM_PORT_W-1:0] upstream_port_select_straps,
	input wire logic irq_request,
	input wire logic [UPSTREAM_PORT_W-1:0] upstream_port_num,
	input wire logic sw_config
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic mask0;
	sequence dbg_wr;
		cfg_wr && cfg_addr == DEBUG_CONTROL_OFS;
	endsequence
	// Shadow of mask bit 0, so the irq check knows when it may fire
	always_ff @(posedge clk) begin
		if (srst) mask0 <= 1'b1;
		else if (cfg_wr && cfg_addr == RAM_ERROR_MASK_OFS) mask0 <= cfg_wdata[0];
	end
	a_irq_needs_enable: assert property (irq_request |-> int_enable)
		else $error("irq without enable");
	a_cpl_raises_irq: assert property (cpl_fifo_ovf && !mask0 && !cfg_wr ##1 int_enable |-> irq_request)
		else $error("unmasked overflow gave no irq");
	a_irq_holds: assert property (irq_request && !cfg_wr ##1 int_enable |-> irq_request)
		else $error("irq dropped without a write");
	a_strap_load: assert property ($fell(srst) |=> upstream_port_num == $past(upstream_port_select_straps))
		else $error("straps not loaded");
	a_port_frozen: assert property (!sw_config && !$past(srst) |=> $stable(upstream_port_num))
		else $error("port moved under strap control");
	a_sw_port_write: assert property (dbg_wr ##0 sw_config |=> upstream_port_num == $past(cfg_wdata[11:8]))
		else $error("software port write lost");
	a_sw_bit_write: assert property (dbg_wr |=> sw_config == $past(cfg_wdata[15]))
		else $error("control source bit wrong");
	a_unmapped_zero: assert property (cfg_rd && cfg_addr == 12'h1d4 |=> cfg_rdata == 32'h0)
		else $error("unmapped read not zero");
endmodule // ram_ecc_err_monitor

// ==== bench/testbench.sv ====
/* Self-checking bench for ram_ecc_err_regs on port 0.
   Assumes the plain strobe register port and a 50 ns clock. */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; $display("ERROR %0t %h %h", $time, a, b); end end
module testbench
	import ram_ecc_err_pkg::*;
;
	localparam logic [31:0] EVB = RAM_BITS | FIFO_BITS;
	logic clk = 0, srst = 1, wr = 0, rd = 0, ie = 0, irq, swc;
	logic [11:0] addr = '0;
	logic [31:0] wd = '0, rdata, ev = '0, v;
	logic [3:0] straps = 4'h2, port;
	int fails = 0, n_checks = 0;
	always #25 clk = ~clk;
	ram_ecc_err_regs #(.PORT_NUM(0)) dut_u (.clk(clk), .srst(srst), .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(addr),
		.cfg_wdata(wd), .cfg_rdata(rdata), .cpl_fifo_ovf(ev[0]), .hdr_fifo_ovf(ev[1]), .dq_ll_2bit_err(ev[5:4]),
		.dq_ll_1bit_err(ev[7:6]), .sq_ll_1bit_ovf(ev[8]), .sq_ll_2bit_err(ev[9]), .retry_1bit_ovf(ev[10]),
		.retry_2bit_err(ev[11]), .sched_2bit_err(ev[14:12]), .sched_1bit_err(ev[18:16]), .tlpid_2bit_err(ev[22:20]),
		.tlpid_1bit_ovf(ev[26:24]), .int_enable(ie), .upstream_port_select_straps(straps), .irq_request(irq),
		.upstream_port_num(port), .sw_config(swc));
	task automatic wrt(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk) {wr, addr, wd} <= {1'b1, a, d};
		@(posedge clk) wr <= 0;
		@(negedge clk);
	endtask
	task automatic rdt(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk) {rd, addr} <= {1'b1, a};
		@(posedge clk) rd <= 0;
		@(negedge clk) d = rdata;
	endtask
	task automatic pulse(input int i);
		@(posedge clk) ev <= 32'h1 << i;
		@(posedge clk) ev <= '0;
		@(negedge clk);
	endtask
	task automatic t_reset();
		rdt(RAM_ERROR_STATUS_OFS, v); `CHK(v, STATUS_RESET)
		rdt(RAM_ERROR_MASK_OFS, v); `CHK(v, EVB | FACTORY_MASK)
		rdt(DEBUG_CONTROL_OFS, v); `CHK(v, 32'h0000_020f)
	endtask
	task automatic t_events();
		for (int i = 0; i < 32; i++) if (EVB[i]) begin
			pulse(i);
			rdt(RAM_ERROR_STATUS_OFS, v); `CHK(v, 32'h1 << i)
			wrt(RAM_ERROR_STATUS_OFS, ~(32'h1 << i));
			rdt(RAM_ERROR_STATUS_OFS, v); `CHK(v, 32'h1 << i)
			wrt(RAM_ERROR_STATUS_OFS, 32'h1 << i);
			rdt(RAM_ERROR_STATUS_OFS, v); `CHK(v, 32'h0)
		end
	endtask
	task automatic t_irq();
		wrt(RAM_ERROR_MASK_OFS, EVB & ~32'h1);
		@(posedge clk) ie <= 1;
		pulse(0); `CHK(irq, 1'b1)
		@(posedge clk) ie <= 0;
		@(negedge clk) `CHK(irq, 1'b0)
		wrt(RAM_ERROR_MASK_OFS, 32'h1);
		@(posedge clk) ie <= 1;
		@(negedge clk) `CHK(irq, 1'b0)
		wrt(RAM_ERROR_MASK_OFS, 32'h0);
		wrt(RAM_ERROR_STATUS_OFS, 32'hffff_ffff);
		pulse(26); `CHK(irq, 1'b1)
		wrt(RAM_ERROR_STATUS_OFS, 32'hffff_ffff); `CHK(irq, 1'b0)
	endtask
	task automatic t_debug();
		wrt(DEBUG_CONTROL_OFS, 32'h0000_0100); `CHK(port, 4'h2)
		wrt(DEBUG_CONTROL_OFS, 32'h0000_8000); `CHK(swc, 1'b1)
		wrt(DEBUG_CONTROL_OFS, 32'h0000_8100); `CHK(port, 4'h1)
		rdt(DEBUG_CONTROL_OFS, v); `CHK(v, 32'h0000_810f)
		rdt(12'h1d4, v); `CHK(v, 32'h0)
	endtask
	task automatic t_collide();
		@(posedge clk) begin
			ev <= 32'h1 << SCHED_2BIT_LSB;
			{wr, addr, wd} <= {1'b1, RAM_ERROR_STATUS_OFS, 32'h1 << SCHED_2BIT_LSB};
		end
		@(posedge clk) begin
			ev <= '0;
			wr <= 0;
		end
		rdt(RAM_ERROR_STATUS_OFS, v); `CHK(v, 32'h1 << SCHED_2BIT_LSB)
	endtask
	task automatic t_rereset();
		@(posedge clk) {srst, straps} <= {1'b1, 4'h1};
		repeat (10) @(posedge clk);
		srst <= 0;
		@(negedge clk) `CHK(port, 4'h0)
		@(negedge clk) `CHK(port, 4'h1)
		`CHK(swc, 1'b0)
		rdt(RAM_ERROR_STATUS_OFS, v); `CHK(v, STATUS_RESET)
		rdt(RAM_ERROR_MASK_OFS, v); `CHK(v, EVB | FACTORY_MASK)
		wrt(DEBUG_CONTROL_OFS, 32'h0000_0200); `CHK(port, 4'h1)
	endtask
	task automatic conclude();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		srst <= 0;
		@(negedge clk);
		t_reset();
		t_events();
		t_irq();
		t_collide();
		t_debug();
		t_rereset();
		conclude();
	end
	// Run needs about 16 us; generous margin
	initial begin
		#200us;
		fails++;
		conclude();
	end
endmodule // testbench
bind ram_ecc_err_regs ram_ecc_err_monitor mon_u (.clk(clk), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
	.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cpl_fifo_ovf(cpl_fifo_ovf),
	.int_enable(int_enable), .upstream_port_select_straps(upstream_port_select_straps),
	.irq_request(irq_request), .upstream_port_num(upstream_port_num), .sw_config(sw_config));
